//--- tdb_pkg.sv
// Package: register map, field layout, reset values and types of the timer double-buffer block
package tdb_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;        // Control: mode and direction
   localparam logic [7:0] OFF_CLR = 8'h04;         // Control B clear, word address
   localparam logic [7:0] OFF_SET = 8'h08;         // Control B set, word address
   localparam logic [7:0] OFF_STATUS = 8'h0c;      // Buffer valid flags, period and compare
   localparam logic [7:0] OFF_SYNCBUSY = 8'h10;    // Synchronisation busy bits
   localparam logic [7:0] OFF_COUNT = 8'h14;       // Counter value, 8-bit or 32-bit by mode
   localparam logic [7:0] OFF_PER = 8'h18;         // Active period
   localparam logic [7:0] OFF_PER_BUF = 8'h1c;     // Period buffer
   localparam logic [7:0] OFF_INTFLAG = 8'h20;     // Sticky event flags, write one to clear
   localparam logic [7:0] OFF_INTMASK = 8'h24;     // Interrupt mask
   localparam logic [7:0] OFF_CMP0 = 8'h30;        // Compare channels, one word each
   localparam logic [7:0] OFF_CMP_BUF0 = 8'h40;    // Compare buffers, one word each

   // Control field positions
   localparam int CTRL_MODE32_BIT = 0;   // 1: 32-bit counter, 0: 8-bit counter
   localparam int CTRL_DOWN_BIT = 1;     // 1: count down
   localparam int CTRL_ENABLE_BIT = 2;   // 1: counter runs
   localparam int LOCK_UPDATE_BIT = 1;   // Lock-update position in control-B set/clear
   localparam int CMD_LSB = 5;           // Command field in control-B set
   localparam int CMD_W = 3;

   // Commands
   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_UPDATE = 3'h3;
   localparam logic [2:0] CMD_READ_SYNC = 3'h4;

   // Reset values
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [31:0] PER_RESET = 32'h0000_00ff;
   localparam logic [31:0] CC_RESET = 32'h0000_0000;
   localparam logic LOCK_RESET = 1'b0;

   // Interrupt event positions
   localparam int EV_UPDATE = 0;   // Hardware or software update took place
   localparam int EV_ERR = 1;      // Write blocked by the access guard
   localparam int EV_W = 2;

   // Read-sync latency in cycles before the snapshot is valid
   localparam int SYNC_CYCLES = 2;

   // APB request grouped for the block
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } tdb_apb_req_t;

   // Counter control
   typedef struct packed {
      logic mode32;
      logic down;
      logic enable;
   } tdb_ctrl_t;

endpackage

//--- tdb_cc_mem.sv
// Compare store: active and buffer words for each channel, registered read port
`timescale 1ns/1ps
module tdb_cc_mem #(
   parameter int N = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Write ports
   input wire logic act_we,
   input wire logic buf_we,
   input wire logic [$clog2(N)-1:0] widx,
   input wire logic [31:0] wdata,
   // Copy buffer into active, one bit per channel
   input wire logic [N-1:0] copy,
   // Registered read port
   input wire logic rbuf,
   input wire logic [$clog2(N)-1:0] ridx,
   output logic [31:0] rdata,
   // Active values for the compare logic
   output logic [N-1:0][31:0] act
);

   // Storage, kept as one state struct
   typedef struct packed {
      logic [N-1:0][31:0] act;
      logic [N-1:0][31:0] bufv;
      logic [31:0] rdata;
   } tdb_mem_st_t;

   tdb_mem_st_t s_q;
   tdb_mem_st_t s_d;

   // Next state: copies first, then writes, then read data
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < N; i++) begin
         if (copy[i]) begin
            s_d.act[i] = s_q.bufv[i];
         end
      end
      if (act_we) begin
         s_d.act[widx] = wdata;
      end
      if (buf_we) begin
         s_d.bufv[widx] = wdata;
      end
      s_d.rdata = rbuf ? s_q.bufv[ridx] : s_q.act[ridx];
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign act = s_q.act;

endmodule

//--- tdb_timer.sv
// Timer double buffering, counter value and APB register file
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module tdb_timer #(
   parameter int NCC = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Compare match per channel
   output logic [NCC-1:0] cc_match
);

   localparam int IW = $clog2(NCC);

   ////////////////////////////////////////////////////////////////////////////////
   // State
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_DONE} tdb_phase_t;

   typedef struct packed {
      tdb_phase_t phase;               // Read pipeline stage
      tdb_pkg::tdb_ctrl_t ctrl;        // Mode, direction, enable
      logic lock;                      // Lock-update bit
      logic [31:0] count;              // Running counter
      logic [31:0] snap;               // Count as last synchronised for reading
      logic [1:0] sync_cnt;            // Read-sync in flight
      logic [31:0] per;                // Active period
      logic [31:0] period_buffer;             // Period buffer
      logic per_v;                     // Period buffer valid
      logic [NCC-1:0] cc_v;            // Compare buffer valid
      logic [tdb_pkg::EV_W-1:0] flag;  // Sticky events
      logic [tdb_pkg::EV_W-1:0] mask;  // Interrupt mask
      logic [31:0] rdata;              // Read data register
      logic err;                       // Error answer for current access
      logic [NCC-1:0] match;           // Registered compare match
   } tdb_st_t;

   tdb_st_t s_q;
   tdb_st_t s_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Address helpers
   function automatic logic is_cc(input logic [7:0] a, input logic [7:0] base);
      return (a >= base) && (a < base + 8'(4 * NCC)) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [IW-1:0] cc_idx(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      return d[IW+1:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic acc;         // Access phase of an APB transfer
   logic wr;          // Write takes effect this edge
   logic rd_start;    // First access cycle of a read
   logic hit_cc;
   logic hit_ccbuf;
   logic [IW-1:0] idx;
   logic [2:0] cmd;
   logic mem_act_we;
   logic mem_buf_we;
   logic [NCC-1:0] copy;
   logic [31:0] mem_rdata;
   logic [NCC-1:0][31:0] cc_act;
   logic hw_update;
   logic sw_update;
   logic do_update;
   logic guard_err;
   logic known;
   logic rd_guard;    // Read of an active word made invalid by a pending buffer

   assign acc = psel && penable;
   assign hit_cc = is_cc(paddr, tdb_pkg::OFF_CMP0);
   assign hit_ccbuf = is_cc(paddr, tdb_pkg::OFF_CMP_BUF0);
   assign idx = hit_cc ? cc_idx(paddr, tdb_pkg::OFF_CMP0) : cc_idx(paddr, tdb_pkg::OFF_CMP_BUF0);
   assign cmd = pwdata[tdb_pkg::CMD_LSB +: tdb_pkg::CMD_W];

   // Reads take two cycles so the memory's registered port can be used
   // Ready stands only in the access phase, never while the bus is idle
   assign pready = acc && (pwrite || s_q.phase == ST_DONE);
   assign rd_start = acc && !pwrite && s_q.phase == ST_IDLE;
   assign wr = acc && pwrite;

   // Known addresses; anything else answers with an error
   always_comb begin
      case (paddr)
         tdb_pkg::OFF_CTRL, tdb_pkg::OFF_CLR, tdb_pkg::OFF_SET, tdb_pkg::OFF_STATUS,
         tdb_pkg::OFF_SYNCBUSY, tdb_pkg::OFF_COUNT, tdb_pkg::OFF_PER, tdb_pkg::OFF_PER_BUF,
         tdb_pkg::OFF_INTFLAG, tdb_pkg::OFF_INTMASK: known = 1'b1;
         default: known = hit_cc || hit_ccbuf;
      endcase
   end

   // Writes to a pending compare active or buffer word, or in 8-bit mode a pending period word, are refused
   always_comb begin
      guard_err = 1'b0;
      if (wr) begin
         if ((paddr == tdb_pkg::OFF_PER || paddr == tdb_pkg::OFF_PER_BUF)
             && s_q.per_v && !s_q.ctrl.mode32) begin
            guard_err = 1'b1;
         end
         if ((hit_cc || hit_ccbuf) && s_q.cc_v[idx]) begin
            guard_err = 1'b1;
         end
      end
   end

   // Reads of an active compare word, or in 8-bit mode the active period, whose buffer is still pending are invalid
   assign rd_guard = !pwrite && ((hit_cc && s_q.cc_v[idx])
                     || (paddr == tdb_pkg::OFF_PER && s_q.per_v && !s_q.ctrl.mode32));

   // Update sources: counter at its end, or the software command
   assign hw_update = s_q.ctrl.enable && (s_q.ctrl.down ? (s_q.count == 32'h0000_0000)
                                                       : (s_q.count == s_q.per));
   assign sw_update = wr && paddr == tdb_pkg::OFF_SET && cmd == tdb_pkg::CMD_UPDATE;
   assign do_update = (hw_update && !s_q.lock) || sw_update;

   assign copy = do_update ? s_q.cc_v : '0;
   assign mem_act_we = wr && hit_cc && !guard_err;
   assign mem_buf_we = wr && hit_ccbuf && !guard_err;

   ////////////////////////////////////////////////////////////////////////////////
   // Compare store
   tdb_cc_mem #(
      .N(NCC)
   ) i_tdb_cc_mem (
      .pclk(pclk),
      .presetn(presetn),
      .act_we(mem_act_we),
      .buf_we(mem_buf_we),
      .widx(idx),
      .wdata(pwdata),
      .copy(copy),
      .rbuf(hit_ccbuf),
      .ridx(idx),
      .rdata(mem_rdata),
      .act(cc_act)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [31:0] rv;
      logic [tdb_pkg::EV_W-1:0] ev;
      rv = 32'h0000_0000;
      ev = '0;
      s_d = s_q;

      // Counter: wraps at period or zero
      if (s_q.ctrl.enable) begin
         if (s_q.ctrl.down) begin
            s_d.count = (s_q.count == 32'h0000_0000) ? s_q.per : s_q.count - 32'h0000_0001;
         end else begin
            s_d.count = (s_q.count == s_q.per) ? 32'h0000_0000 : s_q.count + 32'h0000_0001;
         end
      end
      if (!s_q.ctrl.mode32) begin
         s_d.count[31:8] = 24'h00_0000;   // 8-bit counter keeps upper bits clear
      end

      // Double-buffer transfer and automatic valid clear
      if (do_update) begin
         if (s_q.per_v) begin
            s_d.per = s_q.period_buffer;
         end
         s_d.per_v = 1'b0;
         s_d.cc_v = '0;
         ev[tdb_pkg::EV_UPDATE] = 1'b1;
      end

      // Read-sync pipeline takes a count snapshot after a short delay
      if (s_q.sync_cnt != 2'h0) begin
         s_d.sync_cnt = s_q.sync_cnt - 2'h1;
         if (s_q.sync_cnt == 2'h1) begin
            s_d.snap = s_q.count;
         end
      end

      // Register writes
      if (wr && !guard_err) begin
         case (paddr)
            tdb_pkg::OFF_CTRL: begin
               s_d.ctrl.mode32 = pwdata[tdb_pkg::CTRL_MODE32_BIT];
               s_d.ctrl.down = pwdata[tdb_pkg::CTRL_DOWN_BIT];
               s_d.ctrl.enable = pwdata[tdb_pkg::CTRL_ENABLE_BIT];
            end
            tdb_pkg::OFF_CLR: begin
               if (pwdata[tdb_pkg::LOCK_UPDATE_BIT]) begin
                  s_d.lock = 1'b0;
               end
            end
            tdb_pkg::OFF_SET: begin
               if (pwdata[tdb_pkg::LOCK_UPDATE_BIT]) begin
                  s_d.lock = 1'b1;
               end
               if (cmd == tdb_pkg::CMD_READ_SYNC) begin
                  s_d.sync_cnt = 2'(tdb_pkg::SYNC_CYCLES);
               end
            end
            tdb_pkg::OFF_COUNT: begin
               s_d.count = s_q.ctrl.mode32 ? pwdata : {24'h00_0000, pwdata[7:0]};
            end
            tdb_pkg::OFF_PER: begin
               s_d.per = s_q.ctrl.mode32 ? pwdata : {24'h00_0000, pwdata[7:0]};
            end
            tdb_pkg::OFF_PER_BUF: begin
               // Buffered only in 8-bit mode; 32-bit mode writes straight through
               if (s_q.ctrl.mode32) begin
                  s_d.per = pwdata;
               end else begin
                  s_d.period_buffer = {24'h00_0000, pwdata[7:0]};
                  s_d.per_v = 1'b1;
               end
            end
            tdb_pkg::OFF_INTMASK: begin
               s_d.mask = pwdata[tdb_pkg::EV_W-1:0];
            end
            default: begin
               if (hit_ccbuf) begin
                  s_d.cc_v[idx] = 1'b1;
               end
            end
         endcase
      end

      // Sticky flags: new events win over a write-one clear
      if (guard_err) begin
         ev[tdb_pkg::EV_ERR] = 1'b1;
      end
      if (wr && paddr == tdb_pkg::OFF_INTFLAG) begin
         s_d.flag = s_q.flag & ~pwdata[tdb_pkg::EV_W-1:0];
      end
      s_d.flag = s_d.flag | ev;

      // Read data
      case (paddr)
         tdb_pkg::OFF_CTRL: rv = {29'h0, s_q.ctrl.enable, s_q.ctrl.down, s_q.ctrl.mode32};
         tdb_pkg::OFF_CLR, tdb_pkg::OFF_SET: rv = {30'h0, s_q.lock, 1'b0};
         tdb_pkg::OFF_STATUS: rv = {{(31 - NCC){1'b0}}, s_q.cc_v, s_q.per_v};
         // Busy mirrors the valid flags, plus the read-sync in flight
         tdb_pkg::OFF_SYNCBUSY: rv = {{(30 - NCC){1'b0}}, s_q.cc_v, s_q.per_v,
                                      s_q.sync_cnt != 2'h0};
         tdb_pkg::OFF_COUNT: rv = s_q.snap;
         tdb_pkg::OFF_PER: rv = s_q.per;
         tdb_pkg::OFF_PER_BUF: rv = s_q.period_buffer;
         tdb_pkg::OFF_INTFLAG: rv = {30'h0, s_q.flag};
         tdb_pkg::OFF_INTMASK: rv = {30'h0, s_q.mask};
         default: rv = mem_rdata;
      endcase

      // Read phase and error answer
      case (s_q.phase)
         ST_IDLE: begin
            if (rd_start) begin
               s_d.phase = ST_DONE;
            end
         end
         ST_DONE: begin
            s_d.phase = ST_IDLE;
         end
         default: begin
            s_d.phase = ST_IDLE;
         end
      endcase
      // Captured in the first access cycle so that prdata stands with pready
      if (rd_start) begin
         s_d.rdata = rv;
      end
      // Access to a pending active register is treated as invalid
      s_d.err = !known || guard_err || rd_guard;

      for (int i = 0; i < NCC; i++) begin
         s_d.match[i] = (s_q.count == cc_act[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.count <= tdb_pkg::COUNT_RESET;
         s_q.snap <= tdb_pkg::COUNT_RESET;
         s_q.per <= tdb_pkg::PER_RESET;
         s_q.lock <= tdb_pkg::LOCK_RESET;
         s_q.phase <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = s_q.rdata;
   assign pslverr = acc && pready && (!known || guard_err || rd_guard);
   assign irq = |(s_q.flag & s_q.mask);
   assign cc_match = s_q.match;

endmodule

//--- tdb_timer_props.sv
// Checker for bus timing, error answers and interrupt of the timer block
`timescale 1ns/1ps
module tdb_timer_props #(
   parameter int NCC = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Interrupt and compare
   input wire logic irq,
   input wire logic [NCC-1:0] cc_match
);
   //////////////////////////////////////////////////
   // Helper logic
   logic done;     // Access phase completes now
   logic hole;     // Address with no register behind it
   logic guarded;  // Period or compare address under the access guard
   logic mask_q;   // Guard-error mask bit, tracked from bus writes
   logic mask_d;
   assign done = psel && penable && pready;
   assign hole = (paddr inside {8'h28, 8'h2c}) || (paddr >= 8'h50);
   assign guarded = (paddr inside {8'h18, 8'h1c}) || (paddr[7:4] inside {4'h3, 4'h4});
   // Next mask copy, only a completed write to the mask moves it
   always_comb begin
      mask_d = mask_q;
      if (done && pwrite && paddr == tdb_pkg::OFF_INTMASK) begin
         mask_d = pwdata[tdb_pkg::EV_ERR];
      end
   end
   // Mask copy register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 1'b0;
      end else begin
         mask_q <= mask_d;
      end
   end
   //////////////////////////////////////////////////
   // Assertions
   chk_write_ready: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite |-> pready) else $error("write not answered at once");
   chk_read_wait: assert property (@(posedge pclk) disable iff (!presetn)
      psel && $rose(penable) && !pwrite |-> !pready) else $error("read answered early");
   chk_read_done: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && !pready |=> pready) else $error("read wait too long");
   chk_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable) |-> !pready) else $error("ready outside access");
   chk_hole_err: assert property (@(posedge pclk) disable iff (!presetn)
      done && hole |-> pslverr) else $error("unmapped access not refused");
   chk_plain_ok: assert property (@(posedge pclk) disable iff (!presetn)
      done && (paddr inside {8'h00, 8'h04, 8'h08, 8'h14, 8'h20, 8'h24}) |-> !pslverr)
      else $error("unguarded register refused");
   chk_mask_off: assert property (@(posedge pclk) disable iff (!presetn)
      done && pwrite && paddr == tdb_pkg::OFF_INTMASK && pwdata == 32'h0 |=> ##[0:2] !irq)
      else $error("interrupt stays up with mask clear");
   chk_guard_irq: assert property (@(posedge pclk) disable iff (!presetn)
      done && pwrite && pslverr && guarded && mask_q |=> ##[0:2] irq)
      else $error("guard error raised no interrupt");
endmodule

bind tdb_timer tdb_timer_props #(.NCC(NCC)) i_tdb_timer_props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
   .cc_match(cc_match));

//--- tdb_timer_bench.sv
// Self-checking bench for the timer double-buffer block
`timescale 1ns/1ps
module tdb_timer_bench;
   //////////////////////////////////////////////////
   // Signals
   logic pclk = 1'b0;     // Bus clock, 250 MHz
   logic presetn = 1'b0;  // Held low at start
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [3:0] cc_match;
   int n_mismatch = 0;
   int comparisons = 0;
   always #2 pclk = ~pclk;
   tdb_timer #(.NCC(4)) i_tdb_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .cc_match(cc_match));
   //////////////////////////////////////////////////
   // Tasks
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s at %h expected %h seen %h", nm, a, e, s);
      end
   endtask
   // One bus transfer; psel stays up so a next transfer may follow at once
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_mismatch++;
         test_done();
      end
      r = prdata;
      er = pslverr;
      penable <= 1'b0;
   endtask
   task automatic idle(input int n);
      psel <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] r;
      logic er;
      xfer(1'b1, a, d, r, er);
      chk("write error", a, {31'h0, ee}, {31'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] r;
      logic er;
      xfer(1'b0, a, 32'h0, r, er);
      chk("read error", a, {31'h0, ee}, {31'h0, er});
      if (!ee) begin
         chk("read data", a, e, r);
      end
   endtask
   // Read-sync command, then the snapshot once it has settled
   task automatic count_rd(input logic [31:0] e);
      wr(tdb_pkg::OFF_SET, 32'({tdb_pkg::CMD_READ_SYNC, 5'h0}), 1'b0);
      idle(tdb_pkg::SYNC_CYCLES + 1);
      rd(tdb_pkg::OFF_COUNT, e, 1'b0);
   endtask
   // Status polled until it shows e, bounded by lim reads
   task automatic poll_status(input logic [31:0] e, input int lim);
      logic [31:0] r;
      logic er;
      int k;
      k = 0;
      do begin
         xfer(1'b0, tdb_pkg::OFF_STATUS, 32'h0, r, er);
         k++;
      end while (r !== e && k < lim);
      chk("status", tdb_pkg::OFF_STATUS, e, r);
   endtask
   task automatic irq_is(input logic e);
      idle(3);
      chk("irq", 8'hff, {31'h0, e}, {31'h0, irq});
   endtask
   //////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, counter register, unbuffered period in 32-bit mode
      rd(tdb_pkg::OFF_PER, tdb_pkg::PER_RESET, 1'b0);
      rd(tdb_pkg::OFF_SET, 32'h0, 1'b0);
      count_rd(tdb_pkg::COUNT_RESET);
      wr(tdb_pkg::OFF_CTRL, 32'h1, 1'b0);
      wr(tdb_pkg::OFF_COUNT, 32'h1234_5678, 1'b0);
      count_rd(32'h1234_5678);
      wr(tdb_pkg::OFF_PER + 8'h4, 32'h77, 1'b0);
      rd(tdb_pkg::OFF_STATUS, 32'h0, 1'b0);
      rd(tdb_pkg::OFF_PER, 32'h77, 1'b0);
      // 8-bit mode, stopped and locked: buffers fill and guard the active words
      wr(tdb_pkg::OFF_CTRL, 32'h0, 1'b0);
      wr(tdb_pkg::OFF_COUNT, 32'h0, 1'b0);
      wr(tdb_pkg::OFF_SET, 32'h2, 1'b0);
      wr(tdb_pkg::OFF_INTMASK, 32'h2, 1'b0);
      wr(tdb_pkg::OFF_CMP_BUF0, 32'h11, 1'b0);
      wr(tdb_pkg::OFF_PER + 8'h4, 32'h40, 1'b0);
      rd(tdb_pkg::OFF_STATUS, 32'h3, 1'b0);
      rd(tdb_pkg::OFF_SYNCBUSY, 32'h6, 1'b0);
      wr(tdb_pkg::OFF_CMP0, 32'h5, 1'b1);
      wr(tdb_pkg::OFF_CMP_BUF0, 32'h5, 1'b1);
      wr(tdb_pkg::OFF_PER, 32'h5, 1'b1);
      wr(tdb_pkg::OFF_PER + 8'h4, 32'h5, 1'b1);
      rd(tdb_pkg::OFF_CMP0, 32'h0, 1'b1);
      rd(tdb_pkg::OFF_PER, 32'h0, 1'b1);
      rd(tdb_pkg::OFF_CMP0 + 8'h4, tdb_pkg::CC_RESET, 1'b0);
      irq_is(1'b1);
      // Software update while locked
      wr(tdb_pkg::OFF_SET, 32'({tdb_pkg::CMD_UPDATE, 5'h0}), 1'b0);
      rd(tdb_pkg::OFF_STATUS, 32'h0, 1'b0);
      rd(tdb_pkg::OFF_SYNCBUSY, 32'h0, 1'b0);
      rd(tdb_pkg::OFF_CMP0, 32'h11, 1'b0);
      rd(tdb_pkg::OFF_PER, 32'h40, 1'b0);
      rd(tdb_pkg::OFF_SET, 32'h2, 1'b0);
      // Counter running up: held by the lock, then copied at top once unlocked
      wr(tdb_pkg::OFF_CMP_BUF0 + 8'h4, 32'h22, 1'b0);
      wr(tdb_pkg::OFF_CTRL, 32'h4, 1'b0);
      idle(150);
      rd(tdb_pkg::OFF_STATUS, 32'h4, 1'b0);
      wr(tdb_pkg::OFF_CLR, 32'h2, 1'b0);
      poll_status(32'h0, 100);
      rd(tdb_pkg::OFF_CMP0 + 8'h4, 32'h22, 1'b0);
      // Counting down: copied at zero
      wr(tdb_pkg::OFF_CTRL, 32'h6, 1'b0);
      wr(tdb_pkg::OFF_CMP_BUF0 + 8'h8, 32'h33, 1'b0);
      poll_status(32'h0, 100);
      rd(tdb_pkg::OFF_CMP0 + 8'h8, 32'h33, 1'b0);
      // Interrupt flags and mask, counter stopped
      wr(tdb_pkg::OFF_CTRL, 32'h0, 1'b0);
      // Stopped count meets only the copied channel 1 word
      wr(tdb_pkg::OFF_COUNT, 32'h22, 1'b0);
      idle(2);
      chk("compare match", 8'hfe, 32'h2, {28'h0, cc_match});
      rd(tdb_pkg::OFF_INTFLAG, 32'h3, 1'b0);
      wr(tdb_pkg::OFF_INTMASK, 32'h1, 1'b0);
      irq_is(1'b1);
      wr(tdb_pkg::OFF_INTMASK, 32'h0, 1'b0);
      irq_is(1'b0);
      wr(tdb_pkg::OFF_INTMASK, 32'h3, 1'b0);
      wr(tdb_pkg::OFF_INTFLAG, 32'h1, 1'b0);
      rd(tdb_pkg::OFF_INTFLAG, 32'h2, 1'b0);
      irq_is(1'b1);
      wr(tdb_pkg::OFF_INTFLAG, 32'h2, 1'b0);
      irq_is(1'b0);
      // Unmapped places
      rd(8'h50, 32'h0, 1'b1);
      wr(8'h28, 32'h1, 1'b1);
      idle(2);
      test_done();
   end
endmodule
